// ===== common/hfcs_defs.vh
// Constants for the HDLC FIFO, command and status block.
`ifndef HFCS_DEFS_VH
`define HFCS_DEFS_VH
`define HFCS_CH_B_BASE 7'h40
`define HFCS_CH_SEL_BIT 6
`define HFCS_FIFO_SEL_BIT 5
`define HFCS_REG_STATUS 5'h00
`define HFCS_STATUS_RST 8'h48
`define HFCS_FIFO_BYTES 6'h20
`define HFCS_CMD_RMC 7
`define HFCS_CMD_RHR 6
`define HFCS_CMD_NRREP 5
`define HFCS_CMD_STI 4
`define HFCS_CMD_XTF 3
`define HFCS_CMD_XIF 2
`define HFCS_CMD_XME 1
`define HFCS_CMD_TRANSMITTER_RESET_CMD 0
`define HFCS_CMD_REPEAT 8'h2a
`define HFCS_CEC_CYCLES 2'h2
`define HFCS_ABORT_ONES 3'h7
`define HFCS_MODE_AUTO 2'h0
`define HFCS_MODE_EXT 2'h3
`endif

// ===== hdl/hfcs_fifo.v
// Parameterised flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module hfcs_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire i_mclk,
  input wire i_resetn,
  input wire i_flush,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;
  assign o_in_ready = (cnt_r != DEPTH[AW:0]);
  assign o_out_valid = (cnt_r != {(AW+1){1'b0}});
  assign o_out_data = mem_r[rp_r];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;
  always @(posedge i_mclk) begin
    if (!i_resetn || i_flush) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem_r[wp_r] <= i_in_data;
        wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // hfcs_fifo

// ===== hdl/hfcs_top.v
// One HDLC channel pair: FIFO windows, commands, status and DMA request.
// Function
// - Whole FIFO window reaches current byte
// - First received bit lands in LSB
// - Threshold selects 32, 16, 4, 2 bytes
// - Interrupt mode: pool-full and message-end events
// - Message-complete command frees receive space
// - DMA request held until last read starts
// - Short block requests only remaining bytes
// - DMA message end blocks requests until RX_MESSAGE_COMPLETE_CMD
// - Host writes at most 32 bytes; LSB first
// - Transmit DMA requests full blocks plus remainder
// - Overflow flag on 33rd byte, cleared later
// - Auto-mode busy and awaiting-ack status bits
// - Executing flag at most 2.5 clocks
// - Receiver reset discards data and counters
// - Auto-mode not-ready bit picks RR or RNR
// - Command 2A repeats FIFO cyclically in extended mode
// - Timer start command; timer write stops
// - Transparent transmit starts frame or DMA
// - I-frame command starts auto-mode frame
// - Message end appends CRC and flag outside DMA and extended modes
// - Transmitter reset clears, aborts, reports ready
// - Status byte stored last in each frame
`timescale 1ns/100ps
`include "hfcs_defs.vh"
module hfcs_top #(
  parameter FIFO_DEPTH = 4
) (
  input wire i_mclk,
  input wire i_resetn,
  input wire [6:0] i_addr,
  input wire i_rd,
  input wire i_wr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  input wire [1:0] i_mode_a,
  input wire [1:0] i_mode_b,
  input wire [1:0] i_rx_threshold_sel_a,
  input wire [1:0] i_rx_threshold_sel_b,
  input wire i_dma_mode_a,
  input wire i_dma_mode_b,
  input wire [11:0] i_tx_count_a,
  input wire [11:0] i_tx_count_b,
  input wire i_timer_write_a,
  input wire i_timer_write_b,
  input wire i_remote_busy_a,
  input wire i_remote_busy_b,
  input wire i_awaiting_ack_a,
  input wire i_awaiting_ack_b,
  input wire i_cts_a,
  input wire i_cts_b,
  input wire [1:0] i_rxd,
  input wire [1:0] i_rx_link_clk,
  input wire [1:0] i_rx_frame_end,
  input wire [7:0] i_rx_frame_status,
  input wire [1:0] i_tx_link_clk,
  output reg [1:0] o_txd,
  output wire [1:0] o_rx_dma_request,
  output wire [1:0] o_tx_dma_request,
  output wire [1:0] o_rx_pool_full_irq,
  output wire [1:0] o_rx_message_end_irq,
  output wire [1:0] o_tx_pool_ready_irq,
  output reg [1:0] o_timer_run,
  output reg [1:0] o_send_rnr,
  output reg [1:0] o_seq_reset,
  output reg [1:0] o_iframe_start,
  output reg [1:0] o_append_crc
);
  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  function [5:0] thr_bytes;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: thr_bytes = 6'h20;
        2'h1: thr_bytes = 6'h10;
        2'h2: thr_bytes = 6'h04;
        default: thr_bytes = 6'h02;
      endcase
    end
  endfunction

  function [5:0] tx_block;
    input [11:0] left;
    begin
      if (left >= {6'h00, `HFCS_FIFO_BYTES})
        tx_block = `HFCS_FIFO_BYTES;
      else
        tx_block = left[5:0];
    end
  endfunction

  // ------------------------------------------------------------
  // Per-channel logic
  // ------------------------------------------------------------
  wire [7:0] rx_rdata [0:1];
  wire [7:0] status [0:1];
  wire [1:0] ch_hit;
  assign ch_hit[0] = ~i_addr[`HFCS_CH_SEL_BIT];
  assign ch_hit[1] = i_addr[`HFCS_CH_SEL_BIT];

  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1) begin : g_ch
      wire [1:0] mode = (c == 0) ? i_mode_a : i_mode_b;
      wire dma = (c == 0) ? i_dma_mode_a : i_dma_mode_b;
      wire [1:0] tsel = (c == 0) ? i_rx_threshold_sel_a :
        i_rx_threshold_sel_b;
      wire [11:0] tcnt = (c == 0) ? i_tx_count_a : i_tx_count_b;
      wire twr = (c == 0) ? i_timer_write_a : i_timer_write_b;
      wire rbusy = (c == 0) ? i_remote_busy_a : i_remote_busy_b;
      wire wack = (c == 0) ? i_awaiting_ack_a : i_awaiting_ack_b;
      wire cts = (c == 0) ? i_cts_a : i_cts_b;
      wire auto_m = (mode == `HFCS_MODE_AUTO);
      wire fifo_sel = ~i_addr[`HFCS_FIFO_SEL_BIT];
      wire cmd_wr = i_wr & ch_hit[c] & ~fifo_sel &
        (i_addr[4:0] == `HFCS_REG_STATUS);
      wire rd_fifo = i_rd & ch_hit[c] & fifo_sel;
      wire wr_fifo = i_wr & ch_hit[c] & fifo_sel;

      // Link inputs pass two flops before use.
      reg [1:0] rclk_s_r, rxd_s_r, fe_s_r, tclk_s_r;
      reg rclk_d_r, tclk_d_r;
      always @(posedge i_mclk) begin
        if (!i_resetn) begin
          rclk_s_r <= 2'h0;
          rxd_s_r <= 2'h0;
          fe_s_r <= 2'h0;
          tclk_s_r <= 2'h0;
          rclk_d_r <= 1'b0;
          tclk_d_r <= 1'b0;
        end else begin
          rclk_s_r <= {rclk_s_r[0], i_rx_link_clk[c]};
          rxd_s_r <= {rxd_s_r[0], i_rxd[c]};
          fe_s_r <= {fe_s_r[0], i_rx_frame_end[c]};
          tclk_s_r <= {tclk_s_r[0], i_tx_link_clk[c]};
          rclk_d_r <= rclk_s_r[1];
          tclk_d_r <= tclk_s_r[1];
        end
      end
      wire rx_edge = rclk_s_r[1] & ~rclk_d_r;
      wire tx_edge = ~tclk_s_r[1] & tclk_d_r;
      reg fe_d_r;
      wire fe_pulse = fe_s_r[1] & ~fe_d_r;

      // Receive byte assembly and receive buffer.
      reg [7:0] rsh_r;
      reg [2:0] rbit_r;
      reg [7:0] rbuf_r [0:31];
      reg [5:0] rwp_r, rrp_r, rfree_r, blk_left_r;
      reg rhold_r, rme_r, rpf_r, rdma_blk_r, rstat_pend_r;
      reg cmd_rhr_r;
      wire [5:0] thr = thr_bytes(tsel);
      wire [5:0] rcnt = rwp_r - rrp_r;
      wire full_blk = (rcnt >= thr);
      wire byte_done = rx_edge & (rbit_r == 3'h7);
      wire [7:0] rbyte = {rxd_s_r[1], rsh_r[7:1]};

      wire st_in_ready, st_out_valid;
      wire [7:0] st_out_data;
      wire st_push_data = byte_done & ~rstat_pend_r;
      wire st_in_valid = st_push_data | rstat_pend_r;
      wire [7:0] st_in_data = rstat_pend_r ? i_rx_frame_status : rbyte;
      wire buf_room = (rcnt != `HFCS_FIFO_BYTES);
      hfcs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(2)) u_stage (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_flush(cmd_rhr_r),
        .i_in_valid(st_in_valid),
        .o_in_ready(st_in_ready),
        .i_in_data(st_in_data),
        .o_out_valid(st_out_valid),
        .i_out_ready(buf_room),
        .o_out_data(st_out_data)
      );
      wire buf_push = st_out_valid & buf_room;
      assign rx_rdata[c] = rbuf_r[rrp_r[4:0]];

      always @(posedge i_mclk) begin
        if (!i_resetn || cmd_rhr_r) begin
          rsh_r <= 8'h00;
          rbit_r <= 3'h0;
          rwp_r <= 6'h00;
          rrp_r <= 6'h00;
          rhold_r <= 1'b0;
          rme_r <= 1'b0;
          rpf_r <= 1'b0;
          rdma_blk_r <= 1'b0;
          rstat_pend_r <= 1'b0;
          blk_left_r <= 6'h00;
          fe_d_r <= 1'b0;
        end else begin
          fe_d_r <= fe_s_r[1];
          if (rx_edge) begin
            rsh_r <= rbyte;
            rbit_r <= rbit_r + 3'h1;
          end
          if (fe_pulse) begin
            rstat_pend_r <= 1'b1;
          end else if (rstat_pend_r && st_in_ready) begin
            rstat_pend_r <= 1'b0;
          end
          if (buf_push) begin
            rbuf_r[rwp_r[4:0]] <= st_out_data;
            rwp_r <= rwp_r + 6'h01;
          end
          if (!rhold_r && !rdma_blk_r) begin
            if (full_blk && !fe_d_r) begin
              rhold_r <= 1'b1;
              rpf_r <= ~dma;
              blk_left_r <= thr;
            end else if (fe_d_r && !rstat_pend_r && !st_out_valid &&
                rcnt != 6'h00) begin
              rhold_r <= 1'b1;
              blk_left_r <= rcnt;
              rme_r <= ~dma;
            end
          end
          if (rhold_r && rd_fifo && blk_left_r != 6'h00) begin
            rrp_r <= rrp_r + 6'h01;
            blk_left_r <= blk_left_r - 6'h01;
            if (dma && blk_left_r == 6'h01 && fe_d_r) begin
              rme_r <= 1'b1;
              rdma_blk_r <= 1'b1;
            end
            if (dma && blk_left_r == 6'h01 && !fe_d_r) begin
              rhold_r <= 1'b0;
            end
          end
          if (cmd_wr && i_wdata[`HFCS_CMD_RMC]) begin
            rhold_r <= 1'b0;
            rpf_r <= 1'b0;
            rme_r <= 1'b0;
            rdma_blk_r <= 1'b0;
            blk_left_r <= 6'h00;
            if (!dma) begin
              rrp_r <= rrp_r + blk_left_r;
            end
          end
        end
      end
      // Request stays up until the last read of the block starts.
      assign o_rx_dma_request[c] = dma & rhold_r & ~rdma_blk_r &
        (blk_left_r != 6'h00) & ~(rd_fifo & (blk_left_r == 6'h01));
      assign o_rx_pool_full_irq[c] = rpf_r;
      assign o_rx_message_end_irq[c] = rme_r;

      // Transmit side.
      reg [7:0] tbuf_r [0:31];
      reg [5:0] twp_r, trp_r;
      reg [11:0] tleft_r;
      reg [5:0] treq_r;
      reg tov_r, tsend_r, trep_r, txpr_r, tabort_r;
      reg [2:0] tab_cnt_r, tbit_r;
      reg [1:0] cec_r;
      wire [5:0] tcnt_f = twp_r - trp_r;
      wire cmd_transmitter_reset_cmd = cmd_wr & i_wdata[`HFCS_CMD_TRANSMITTER_RESET_CMD];
      wire cmd_go = cmd_wr & (i_wdata[`HFCS_CMD_XTF] |
        (i_wdata[`HFCS_CMD_XIF] & auto_m));
      always @(posedge i_mclk) begin
        if (!i_resetn || cmd_transmitter_reset_cmd) begin
          twp_r <= 6'h00;
          trp_r <= 6'h00;
          tov_r <= 1'b0;
          tsend_r <= 1'b0;
          trep_r <= 1'b0;
          tleft_r <= 12'h000;
          treq_r <= 6'h00;
          tbit_r <= 3'h0;
          o_txd[c] <= 1'b1;
          txpr_r <= 1'b1;
          tabort_r <= i_resetn;
          tab_cnt_r <= `HFCS_ABORT_ONES;
          o_iframe_start[c] <= 1'b0;
          o_append_crc[c] <= 1'b0;
        end else begin
          o_iframe_start[c] <= cmd_wr & i_wdata[`HFCS_CMD_XIF] & auto_m;
          o_append_crc[c] <= cmd_wr & i_wdata[`HFCS_CMD_XME] & ~dma &
            (mode != `HFCS_MODE_EXT);
          if (wr_fifo) begin
            if (tcnt_f == `HFCS_FIFO_BYTES) begin
              tov_r <= 1'b1;
            end else begin
              tbuf_r[twp_r[4:0]] <= i_wdata;
              twp_r <= twp_r + 6'h01;
              txpr_r <= 1'b0;
              if (treq_r != 6'h00) begin
                treq_r <= treq_r - 6'h01;
              end
            end
          end
          if (cmd_go) begin
            tsend_r <= 1'b1;
            trep_r <= (i_wdata == `HFCS_CMD_REPEAT) &&
              (mode == `HFCS_MODE_EXT);
            if (dma) begin
              tleft_r <= tcnt;
              treq_r <= tx_block(tcnt);
            end
          end
          if (tabort_r && tx_edge) begin
            o_txd[c] <= 1'b1;
            tab_cnt_r <= tab_cnt_r - 3'h1;
            if (tab_cnt_r == 3'h1) begin
              tabort_r <= 1'b0;
              txpr_r <= 1'b1;
            end
          end else if (tsend_r && tx_edge && tcnt_f != 6'h00 &&
              (!dma || tcnt_f == `HFCS_FIFO_BYTES || treq_r == 6'h00)) begin
            o_txd[c] <= tbuf_r[trp_r[4:0]][tbit_r];
            tbit_r <= tbit_r + 3'h1;
            if (tbit_r == 3'h7) begin
              if (trep_r && trp_r + 6'h01 == twp_r) begin
                trp_r <= 6'h00;
              end else begin
                trp_r <= trp_r + 6'h01;
                tov_r <= 1'b0;
              end
              if (dma && tleft_r != 12'h000) begin
                tleft_r <= tleft_r - 12'h001;
                if (treq_r == 6'h00 && tcnt_f == 6'h01) begin
                  treq_r <= tx_block(tleft_r - 12'h001);
                end
              end
              if (!trep_r && tcnt_f == 6'h01) begin
                tsend_r <= 1'b0;
                txpr_r <= 1'b1;
              end
            end
          end
        end
      end
      assign o_tx_dma_request[c] = dma & tsend_r & (treq_r != 6'h00);
      assign o_tx_pool_ready_irq[c] = txpr_r;

      // Command pulses, executing flag, timer and auto-mode controls.
      always @(posedge i_mclk) begin
        if (!i_resetn) begin
          cec_r <= 2'h0;
          cmd_rhr_r <= 1'b0;
          o_timer_run[c] <= 1'b0;
          o_send_rnr[c] <= 1'b0;
          o_seq_reset[c] <= 1'b0;
        end else begin
          cmd_rhr_r <= cmd_wr & i_wdata[`HFCS_CMD_RHR];
          o_seq_reset[c] <= cmd_wr & i_wdata[`HFCS_CMD_RHR] & auto_m;
          if (cmd_wr) begin
            cec_r <= `HFCS_CEC_CYCLES;
          end else if (cec_r != 2'h0) begin
            cec_r <= cec_r - 2'h1;
          end
          if (cmd_wr && i_wdata[`HFCS_CMD_STI]) begin
            o_timer_run[c] <= 1'b1;
          end else if (twr) begin
            o_timer_run[c] <= 1'b0;
          end
          if (cmd_wr && auto_m) begin
            o_send_rnr[c] <= i_wdata[`HFCS_CMD_NRREP];
          end
        end
      end
      // Busy bits read zero outside auto-mode.
      assign status[c] = {tov_r, (tcnt_f == 6'h00) & ~tabort_r,
        o_send_rnr[c] & auto_m, rbusy & auto_m, (rbit_r == 3'h0) & ~rhold_r,
        (cec_r != 2'h0), cts, wack & auto_m};
    end
  endgenerate

  // ------------------------------------------------------------
  // Read data register
  // ------------------------------------------------------------
  wire rsel = i_addr[`HFCS_CH_SEL_BIT];
  always @(posedge i_mclk) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      if (!i_addr[`HFCS_FIFO_SEL_BIT]) begin
        o_rdata <= rx_rdata[rsel];
      end else if (i_addr[4:0] == `HFCS_REG_STATUS) begin
        o_rdata <= status[rsel];
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end
endmodule // hfcs_top

// ===== testbench/hfcs_top_asserts.sv
// Assertion checker for the HDLC FIFO, command and status block.
`timescale 1ns/100ps
module hfcs_top_asserts #(
  parameter FIFO_DEPTH = 4
) (
  input wire i_mclk,
  input wire i_resetn,
  input wire [6:0] i_addr,
  input wire i_rd,
  input wire i_wr,
  input wire [7:0] i_wdata,
  input wire [7:0] o_rdata,
  input wire [1:0] i_mode_a,
  input wire i_dma_mode_a,
  input wire i_dma_mode_b,
  input wire i_timer_write_a,
  input wire i_remote_busy_a,
  input wire i_awaiting_ack_a,
  input wire [1:0] o_rx_dma_request,
  input wire [1:0] o_tx_dma_request,
  input wire [1:0] o_timer_run,
  input wire [1:0] o_send_rnr,
  input wire [1:0] o_seq_reset,
  input wire [1:0] o_iframe_start
);
  reg [2:0] since_cmd_r;
  wire cmd_a = i_wr && i_addr == 7'h20;
  wire auto_a = i_mode_a == 2'h0;
  // Saturating age of the last command, so the busy window can be bounded.
  always @(posedge i_mclk) begin
    if (!i_resetn) begin
      since_cmd_r <= 3'h7;
    end else if (cmd_a) begin
      since_cmd_r <= 3'h0;
    end else if (since_cmd_r != 3'h7) begin
      since_cmd_r <= since_cmd_r + 3'h1;
    end
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  sequence s_auto_cmd(int b);
    cmd_a && i_wdata[b] ##0 auto_a;
  endsequence
  sequence s_stat_rd;
    i_rd && i_addr == 7'h20;
  endsequence
  a_rx_dma_gate: assert property (
    (o_rx_dma_request & ~{i_dma_mode_b, i_dma_mode_a}) == 2'h0)
    else $error("receive DMA request outside DMA mode");
  a_tx_dma_gate: assert property (
    (o_tx_dma_request & ~{i_dma_mode_b, i_dma_mode_a}) == 2'h0)
    else $error("transmit DMA request outside DMA mode");
  a_rdata_stands: assert property (
    $past(i_resetn) && !$past(i_rd) |-> $stable(o_rdata))
    else $error("read data changed without a read");
  a_timer_start: assert property (
    cmd_a && i_wdata[4] |-> ##[1:4] o_timer_run[0])
    else $error("timer did not start");
  a_timer_stop: assert property (
    i_timer_write_a |-> ##[1:4] !o_timer_run[0])
    else $error("timer did not stop on timer write");
  a_rnr_select: assert property (
    s_auto_cmd(5) |-> ##[1:4] o_send_rnr[0])
    else $error("not-ready acknowledgement not selected");
  a_seq_reset: assert property (
    s_auto_cmd(6) |-> ##[1:4] o_seq_reset[0])
    else $error("sequence counters not reset");
  a_iframe_start: assert property (
    s_auto_cmd(2) |-> ##[1:4] o_iframe_start[0])
    else $error("I-frame not started");
  a_cec_bound: assert property (
    s_stat_rd ##0 (since_cmd_r >= 3'h3) |=> !o_rdata[2])
    else $error("executing flag held too long");
  a_auto_status: assert property (
    s_stat_rd ##0 auto_a |=> o_rdata[4] == $past(i_remote_busy_a)
      && o_rdata[0] == $past(i_awaiting_ack_a))
    else $error("auto-mode status bits wrong");
endmodule // hfcs_top_asserts
bind hfcs_top hfcs_top_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) i_hfcs_top_asserts (
  .i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_rd(i_rd),
  .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_mode_a(i_mode_a),
  .i_dma_mode_a(i_dma_mode_a), .i_dma_mode_b(i_dma_mode_b),
  .i_timer_write_a(i_timer_write_a), .i_remote_busy_a(i_remote_busy_a),
  .i_awaiting_ack_a(i_awaiting_ack_a), .o_rx_dma_request(o_rx_dma_request),
  .o_tx_dma_request(o_tx_dma_request), .o_timer_run(o_timer_run),
  .o_send_rnr(o_send_rnr), .o_seq_reset(o_seq_reset),
  .o_iframe_start(o_iframe_start)
);

// ===== testbench/hfcs_remote.sv
// Far station model: serial frame source for both receive channels.
`timescale 1ns/100ps
module hfcs_remote (
  output reg [1:0] o_rxd,
  output reg [1:0] o_rx_link_clk,
  output reg [1:0] o_rx_frame_end,
  output reg [7:0] o_rx_frame_status,
  output reg [1:0] o_tx_link_clk
);
  // The transmit clock runs free because the line carries time-fill.
  initial begin
    o_rxd = 2'h3;
    o_rx_link_clk = 2'h0;
    o_rx_frame_end = 2'h0;
    o_rx_frame_status = 8'h00;
    o_tx_link_clk = 2'h0;
    #7;
    forever #32 o_tx_link_clk = ~o_tx_link_clk;
  end
  // Sends n bytes of data, low byte first, each least significant bit first.
  task send_frame(input logic [31:0] data, input int n, input logic [7:0] st);
    int i;
    for (i = 0; i < n * 8; i++) begin
      o_rxd = {2{data[i]}};
      #32 o_rx_link_clk = 2'h3;
      #32 o_rx_link_clk = 2'h0;
    end
    o_rxd = {2{~data[n*8-1]}};
    o_rx_frame_status = st;
    o_rx_frame_end = 2'h3;
    #128 o_rx_frame_end = 2'h0;
    #256 o_rx_frame_status = ~st;
  endtask
endmodule // hfcs_remote

// ===== testbench/tb.sv
// Self-checking testbench for the HDLC FIFO, command and status block.
`timescale 1ns/100ps
module tb;
  reg i_mclk, i_resetn, i_rd, i_wr, i_dma_mode_a, i_dma_mode_b;
  reg i_timer_write_a, i_timer_write_b, i_cts_a, i_cts_b;
  reg i_remote_busy_a, i_remote_busy_b, i_awaiting_ack_a, i_awaiting_ack_b;
  reg [6:0] i_addr;
  reg [7:0] i_wdata;
  reg [1:0] i_mode_a, i_mode_b, i_thr_a, i_thr_b;
  reg [11:0] i_tx_count_a, i_tx_count_b;
  wire [7:0] o_rdata, rx_status;
  wire [1:0] rxd, rx_clk, rx_end, tx_clk, o_txd, o_rx_dma_request;
  wire [1:0] o_tx_dma_request, o_rx_pool_full_irq, o_rx_message_end_irq;
  wire [1:0] o_tx_pool_ready_irq, o_timer_run, o_send_rnr, o_seq_reset;
  wire [1:0] o_iframe_start, o_append_crc;
  int fails = 0;
  int n_tests = 0;
  hfcs_top #(.FIFO_DEPTH(4)) i_hfcs_top (.i_mclk(i_mclk),
    .i_resetn(i_resetn), .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_mode_a(i_mode_a),
    .i_mode_b(i_mode_b), .i_rx_threshold_sel_a(i_thr_a),
    .i_rx_threshold_sel_b(i_thr_b), .i_dma_mode_a(i_dma_mode_a),
    .i_dma_mode_b(i_dma_mode_b), .i_tx_count_a(i_tx_count_a),
    .i_tx_count_b(i_tx_count_b), .i_timer_write_a(i_timer_write_a),
    .i_timer_write_b(i_timer_write_b), .i_remote_busy_a(i_remote_busy_a),
    .i_remote_busy_b(i_remote_busy_b), .i_awaiting_ack_a(i_awaiting_ack_a),
    .i_awaiting_ack_b(i_awaiting_ack_b), .i_cts_a(i_cts_a), .i_cts_b(i_cts_b),
    .i_rxd(rxd), .i_rx_link_clk(rx_clk), .i_rx_frame_end(rx_end),
    .i_rx_frame_status(rx_status), .i_tx_link_clk(tx_clk), .o_txd(o_txd),
    .o_rx_dma_request(o_rx_dma_request), .o_tx_dma_request(o_tx_dma_request),
    .o_rx_pool_full_irq(o_rx_pool_full_irq),
    .o_rx_message_end_irq(o_rx_message_end_irq),
    .o_tx_pool_ready_irq(o_tx_pool_ready_irq), .o_timer_run(o_timer_run),
    .o_send_rnr(o_send_rnr), .o_seq_reset(o_seq_reset),
    .o_iframe_start(o_iframe_start), .o_append_crc(o_append_crc));
  hfcs_remote i_hfcs_remote (.o_rxd(rxd), .o_rx_link_clk(rx_clk),
    .o_rx_frame_end(rx_end), .o_rx_frame_status(rx_status),
    .o_tx_link_clk(tx_clk));
  // ----------------------------------------------------------------------
  // Bus, wait and compare helpers
  // ----------------------------------------------------------------------
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(negedge i_mclk);
    i_wr = 1'b0;
  endtask
  task rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge i_mclk);
    i_addr = a;
    i_rd = 1'b1;
    @(negedge i_mclk);
    i_rd = 1'b0;
    d = o_rdata;
  endtask
  // Waits out the executing flag so that no command is lost.
  task cmd(input logic [6:0] a, input logic [7:0] c);
    logic [7:0] s;
    int k;
    for (k = 0; k < 8; k++) begin
      rd(a, s);
      if (s[2] === 1'b0) break;
    end
    chk("executing flag", 8'h00, {7'h0, s[2]});
    wr(a, c);
  endtask
  function logic pick(input int w);
    case (w)
      0: pick = o_rx_pool_full_irq[0];
      1: pick = o_rx_message_end_irq[0];
      2: pick = o_rx_dma_request[0];
      3: pick = o_append_crc[0];
      4: pick = o_seq_reset[0];
      5: pick = o_iframe_start[0];
      default: pick = o_tx_pool_ready_irq[0];
    endcase
  endfunction
  task wait_hi(input int w, input int lim, input string what);
    int k;
    for (k = 0; k < lim && pick(w) !== 1'b1; k++) @(negedge i_mclk);
    chk(what, 8'h01, {7'h0, pick(w)});
  endtask
  task pulse_timer_write(input int ch);
    @(negedge i_mclk);
    if (ch == 0) i_timer_write_a = 1'b1; else i_timer_write_b = 1'b1;
    @(negedge i_mclk);
    i_timer_write_a = 1'b0;
    i_timer_write_b = 1'b0;
    repeat (5) @(negedge i_mclk);
  endtask
  // Reads while the request stands until message end, checking the first four bytes as read, then compares the count.
  task dma_drain(input logic [31:0] w, input int n);
    logic [7:0] d;
    int k, got;
    got = 0;
    for (k = 0; k < 6000 && o_rx_message_end_irq[0] !== 1'b1; k++) begin
      if (o_rx_dma_request[0] === 1'b1) begin
        rd(7'h00, d);
        if (got < 4) chk("dma byte", w[8*got +: 8], d);
        got++;
      end else @(negedge i_mclk);
    end
    chk("dma read count", n[7:0], got[7:0]);
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task t_reset_regs;
    logic [7:0] d;
    rd(7'h20, d);
    chk("status a", 8'h48, d);
    rd(7'h60, d);
    chk("status b", 8'h48, d);
    wr(7'h21, 8'h00);
    rd(7'h20, d);
    chk("status after stray write", 8'h48, d);
    chk("pool ready", 8'h03, {6'h0, o_tx_pool_ready_irq});
  endtask
  task t_auto_status;
    logic [7:0] d;
    i_remote_busy_a = 1'b1;
    i_awaiting_ack_a = 1'b1;
    i_awaiting_ack_b = 1'b1;
    i_cts_a = 1'b1;
    rd(7'h20, d);
    chk("auto status a", 8'h11, d & 8'h11);
    rd(7'h60, d);
    chk("auto status b", 8'h01, d & 8'h11);
    i_remote_busy_a = 1'b0;
    i_awaiting_ack_a = 1'b0;
    i_awaiting_ack_b = 1'b0;
    i_cts_b = 1'b1;
  endtask
  task t_commands;
    cmd(7'h20, 8'h30);
    chk("send rnr", 8'h01, {7'h0, o_send_rnr[0]});
    chk("timer run a", 8'h01, {7'h0, o_timer_run[0]});
    pulse_timer_write(0);
    chk("timer stop a", 8'h00, {7'h0, o_timer_run[0]});
    cmd(7'h20, 8'h10);
    chk("send rr", 8'h00, {7'h0, o_send_rnr[0]});
    pulse_timer_write(0);
    cmd(7'h60, 8'h10);
    chk("timer run b", 8'h01, {7'h0, o_timer_run[1]});
    pulse_timer_write(1);
    chk("timer stop b", 8'h00, {7'h0, o_timer_run[1]});
    cmd(7'h20, 8'h40);
    wait_hi(4, 6, "sequence reset");
    cmd(7'h20, 8'h04);
    wait_hi(5, 6, "iframe start");
    cmd(7'h20, 8'h01);
  endtask
  task t_rx_irq;
    logic [7:0] d;
    i_thr_a = 2'h3;
    fork
      i_hfcs_remote.send_frame(32'h005a3ca5, 3, 8'hc1);
    join_none
    wait_hi(0, 3000, "pool full");
    rd(7'h00, d);
    chk("rx byte 0", 8'ha5, d);
    rd(7'h1f, d);
    chk("rx byte 1", 8'h3c, d);
    cmd(7'h20, 8'h80);
    chk("pool full freed", 8'h00, {7'h0, o_rx_pool_full_irq[0]});
    wait_hi(1, 6000, "message end");
    rd(7'h07, d);
    chk("rx byte 2", 8'h5a, d);
    rd(7'h13, d);
    chk("rx status byte", 8'hc1, d);
    cmd(7'h20, 8'h80);
    chk("message end freed", 8'h00, {7'h0, o_rx_message_end_irq[0]});
  endtask
  task t_rx_dma;
    int k, seen;
    i_dma_mode_a = 1'b1;
    fork
      i_hfcs_remote.send_frame(32'h00332211, 3, 8'h80);
    join_none
    dma_drain(32'h80332211, 4);
    fork
      i_hfcs_remote.send_frame(32'h00000044, 1, 8'h80);
    join_none
    seen = 0;
    for (k = 0; k < 300; k++) begin
      @(negedge i_mclk);
      if (o_rx_dma_request[0] !== 1'b0) seen++;
    end
    chk("request before complete", 8'h00, seen[7:0]);
    cmd(7'h20, 8'h80);
    wait_hi(2, 50, "dma request");
    dma_drain(32'h00008044, 2);
    cmd(7'h20, 8'h80);
    i_dma_mode_a = 1'b0;
  endtask
  task t_tx;
    logic [7:0] d;
    int k;
    for (k = 0; k < 33; k++) begin
      wr(7'h00 + k[6:0] % 7'h20, k[7:0]);
      rd(7'h20, d);
      chk("overflow flag", k == 32 ? 8'h80 : 8'h00, d & 8'h80);
    end
    cmd(7'h20, 8'h01);
    rd(7'h20, d);
    chk("overflow cleared", 8'h00, d & 8'h80);
    wait_hi(6, 3000, "pool ready after reset");
    wr(7'h00, 8'h96);
    wr(7'h11, 8'h0f);
    cmd(7'h20, 8'h0a);
    wait_hi(3, 3000, "crc append");
  endtask
  // ----------------------------------------------------------------------
  // Clock, reset, sequence and verdict
  // ----------------------------------------------------------------------
  task give_verdict;
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  initial begin
    #(60000 * 5);
    fails++;
    give_verdict;
  end
  initial begin
    {i_resetn, i_rd, i_wr, i_dma_mode_a, i_dma_mode_b} = 5'h00;
    {i_timer_write_a, i_timer_write_b, i_cts_a, i_cts_b} = 4'h0;
    {i_remote_busy_a, i_remote_busy_b} = 2'h0;
    {i_awaiting_ack_a, i_awaiting_ack_b} = 2'h0;
    i_addr = 7'h00;
    i_wdata = 8'h00;
    {i_mode_a, i_mode_b, i_thr_a, i_thr_b} = 8'h00;
    i_tx_count_a = 12'h000;
    i_tx_count_b = 12'h000;
    repeat (4) @(negedge i_mclk);
    i_resetn = 1'b1;
    t_reset_regs;
    t_auto_status;
    t_commands;
    t_rx_irq;
    t_rx_dma;
    t_tx;
    give_verdict;
  end
endmodule // tb
